// file: inc/scp_defs.svh
// offsets, field positions, reset values and address constants for the serial control port
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH
`define SCP_OFS_SYNC_STATUS   8'h14
`define SCP_OFS_OUT_FORMAT    8'h15
`define SCP_OFS_BW_PLL        8'h16
`define SCP_OFS_RED_TARGET    8'h19
`define SCP_OFS_GREEN_TARGET  8'h1A
`define SCP_OFS_BLUE_TARGET   8'h1B
`define SCP_OFS_AOFS_CTRL     8'h1D
`define SCP_SLAVE_ADDR_HI     6'h26
`define SCP_BIT_COAST_POL     0
`define SCP_BIT_FMT_444       1
`define SCP_BIT_PLL_DIV2      7
`define SCP_BIT_SOG_BW_HI     6
`define SCP_BIT_SOG_BW_LO     5
`define SCP_BIT_ANA_BW        4
`define SCP_BIT_AOFS_EN       7
`define SCP_BIT_AOFS_HOLD     6
`define SCP_RST_OUT_FORMAT    8'h02
`define SCP_RST_BW_PLL        8'h00
`define SCP_RST_TARGET        8'h04
`define SCP_RST_AOFS_CTRL     8'h02
`define SCP_RATE_EVERY        8'h01
`define SCP_RATE_16           8'h10
`define SCP_RATE_64           8'h40
`endif

// file: inc/scp_pkg.sv
// types shared by the serial control port design
package scp_pkg;
  typedef enum logic [1:0] {
    SCP_SOG_BW_300M,
    SCP_SOG_BW_13M,
    SCP_SOG_BW_6M5
  } scp_sog_bw_t;

  // decoded control fields handed to the analog and output logic
  typedef struct packed {
    logic        fmt_444;
    logic        pll_extra_div2;
    scp_sog_bw_t sog_bw;
    logic        analog_bw_7m;
    logic        aofs_enable;
    logic        aofs_hold;
    logic [7:0]  aofs_rate;
    logic [7:0]  red_target;
    logic [7:0]  green_target;
    logic [7:0]  blue_target;
  } scp_ctrl_t;
endpackage

// file: src/scp_sync2.sv
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module scp_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      q        <= INIT;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: src/scp_regs.sv
// two-wire slave port with its control and status registers
// Function
// - first byte after start: seven address bits then one direction bit
// - direction bit 1 means read from slave, 0 means write
// - matching address is acknowledged low on ninth clock, else released
// - own address has fixed upper bits, lowest bit from select pin
// - every byte is shifted most significant bit first
// - data changes only while clock low; change while high is start/stop
// - start is data falling with clock high, stop is data rising
// - unacknowledged write leaves data released so master can stop
// - read byte not acknowledged by master ends data, line released
// - write: byte after address is base pointer, data stored, pointer increments
// - read starts at earlier base pointer and increments after each byte
// - repeated start without stop is accepted
// - sync status bit 0 reports coast polarity, 1 positive
// - format bit 1: 0 selects 4:2:2, 1 selects 4:4:4
// - in 4:2:2 red carries U/V, green Y, blue high impedance
// - bandwidth register bit 7 adds extra divide-by-2 to PLL
// - bits 6-5 select green sync bandwidth 300, 13, 13, 6.5 MHz
// - bit 4 selects colour input bandwidth 300 MHz or 7 MHz
// - three target registers hold auto-offset goals, each resets to 4
// - control bit 7 enables auto-offset, bit 6 holds it, both reset 0
// - control bits 1:0 set update rate 1, 16, 64 clamp cycles, reset 10
`timescale 1ns/1ps
`default_nettype none
`include "scp_defs.svh"
module scp_regs
  import scp_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rstn,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       sda_out,
  output logic       sda_oe_n,
  input  wire logic  address_select_pins,
  input  wire logic  coast_polarity_in,
  output scp_ctrl_t  ctrl,
  output logic       red_is_chroma,
  output logic       green_is_luma,
  output logic       blue_oe_n
);
  // byte phases of a frame; ignore sits out the frame until the next start
  typedef enum logic [2:0] {
    SCP_IDLE,
    SCP_ADDR,
    SCP_PTR,
    SCP_WDATA,
    SCP_RDATA,
    SCP_IGNORE
  } scp_state_t;

  logic       rst_meta_reg;
  logic       rst_sync_n;
  logic [2:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       sel_s;
  logic       coast_s;
  logic       scl_d_reg;
  logic       sda_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  // pins idle high, so the bus synchroniser resets high to avoid a false start; the coast synchroniser resets low
  scp_sync2 #(.WIDTH(3), .INIT(3'h7)) u_sync_bus (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .d     ({scl_in, sda_in, address_select_pins}),
    .q     (pins_s)
  );
  scp_sync2 #(.WIDTH(1), .INIT(1'b0)) u_sync_coast (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .d     (coast_polarity_in),
    .q     (coast_s)
  );
  assign scl_s = pins_s[2];
  assign sda_s = pins_s[1];
  assign sel_s = pins_s[0];

  // previous synchronised levels for edge detection
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus condition decode
  wire scl_rise  = scl_s & ~scl_d_reg;
  wire scl_fall  = ~scl_s & scl_d_reg;
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire [6:0] own_addr = {`SCP_SLAVE_ADDR_HI, sel_s};

  scp_state_t state_reg;
  scp_state_t state_next;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] ptr_reg;
  logic       ack_phase_reg;
  logic       ack_drive_reg;
  logic       sda_out_reg;
  logic       sda_oe_n_reg;

  // registers
  logic [7:0] fmt_reg;
  logic [7:0] bw_reg;
  logic [7:0] red_tgt_reg;
  logic [7:0] green_tgt_reg;
  logic [7:0] blue_tgt_reg;
  logic [7:0] aofs_reg;

  // byte completes on the eighth rising clock of a byte
  wire byte_done = scl_rise & ~ack_phase_reg & (bit_cnt_reg == 4'h7);
  wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
  wire addr_match = (rx_byte[7:1] == own_addr);
  wire dir_read   = rx_byte[0];
  wire wr_strobe  = byte_done & (state_reg == SCP_WDATA);
  // ninth clock of a read data byte, where the master answers; the address
  // ack of a read is excluded because the port itself holds the line there
  wire master_ack_slot = scl_rise & ack_phase_reg & ~ack_drive_reg
                       & (state_reg == SCP_RDATA);
  wire master_nack     = master_ack_slot & sda_s;

  // read multiplexer; unmapped offsets and the seven upper status bits read zero
  wire [7:0] status_val = {7'h00, coast_s};
  logic [7:0] rd_data;
  always_comb begin
    rd_data = 8'h00;
    case (ptr_reg)
      `SCP_OFS_SYNC_STATUS:  rd_data = status_val;
      `SCP_OFS_OUT_FORMAT:   rd_data = fmt_reg;
      `SCP_OFS_BW_PLL:       rd_data = bw_reg;
      `SCP_OFS_RED_TARGET:   rd_data = red_tgt_reg;
      `SCP_OFS_GREEN_TARGET: rd_data = green_tgt_reg;
      `SCP_OFS_BLUE_TARGET:  rd_data = blue_tgt_reg;
      `SCP_OFS_AOFS_CTRL:    rd_data = aofs_reg;
      default:               rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // protocol state after each byte and on start/stop
  always_comb begin
    state_next = state_reg;
    if (start_det) begin
      state_next = SCP_ADDR;
    end else if (stop_det) begin
      state_next = SCP_IDLE;
    end else if (byte_done) begin
      case (state_reg)
        SCP_ADDR:  state_next = !addr_match ? SCP_IGNORE
                              : (dir_read ? SCP_RDATA : SCP_PTR);
        SCP_PTR:   state_next = SCP_WDATA;
        default:   state_next = state_reg;
      endcase
    end else if (master_nack) begin
      state_next = SCP_IGNORE;
    end
  end

  // bit counter, shifter, ack phase tracking; a start in mid-byte clears
  // the counter so a repeated start always realigns to a fresh address byte
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg      <= SCP_IDLE;
      shift_reg      <= 8'h00;
      bit_cnt_reg    <= 4'h0;
      ack_phase_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start_det) begin
        bit_cnt_reg   <= 4'h0;
        ack_phase_reg <= 1'b0;
      end else if (scl_rise) begin
        if (ack_phase_reg) begin
          bit_cnt_reg   <= 4'h0; // ninth clock closes the byte
          ack_phase_reg <= 1'b0;
        end else begin
          shift_reg   <= rx_byte;
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          ack_phase_reg <= (bit_cnt_reg == 4'h7);
        end
      end
    end
  end

  // register pointer: loaded by the base byte, bumped after each data byte;
  // it survives a stop so a later read starts at the written base, and it
  // wraps from 8'hFF back to 8'h00
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ptr_reg <= 8'h00;
    end else if (byte_done & (state_reg == SCP_PTR)) begin
      ptr_reg <= rx_byte;
    end else if (wr_strobe) begin
      ptr_reg <= ptr_reg + 8'h01;
    end else if (master_ack_slot) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sda driver; a low is taken or changed only on falling scl, so data is stable while scl high
  wire ack_now = byte_done & ((state_reg == SCP_ADDR) ? addr_match
                 : ((state_reg == SCP_PTR) | (state_reg == SCP_WDATA)));
  wire rd_active = (state_reg == SCP_RDATA) & ~ack_phase_reg;
  wire [2:0] rd_bit_idx = 3'h7 - bit_cnt_reg[2:0];
  logic [7:0] tx_reg;

  // the ack flag alone decides the ninth clock, so a read address is
  // acknowledged just like a write; read data bytes leave the flag clear
  wire drive_ack = ack_phase_reg & ack_drive_reg;
  wire rd_bit    = (bit_cnt_reg == 4'h0) ? rd_data[7] : tx_reg[rd_bit_idx];
  // released at once on start, stop, idle or ignore, whatever the clock does
  wire line_free = start_det | stop_det | (state_next == SCP_IDLE)
                 | (state_next == SCP_IGNORE);
  // first read bit comes straight from the multiplexer, the rest from a copy
  // taken at that edge, so a pointer bump cannot tear a byte in flight
  wire tx_load   = scl_fall & (bit_cnt_reg == 4'h0) & ~ack_phase_reg;

  // acknowledge flag follows each completed byte and clears on start/stop
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ack_drive_reg <= 1'b0;
    end else if (start_det | stop_det) begin
      ack_drive_reg <= 1'b0;
    end else if (byte_done) begin
      ack_drive_reg <= ack_now;
    end
  end

  // copy of the byte being read out
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_reg <= 8'h00;
    end else if (tx_load) begin
      tx_reg <= rd_data;
    end
  end

  // a one releases the line, so level and enable always move together
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sda_out_reg  <= 1'b1;
      sda_oe_n_reg <= 1'b1;
    end else if (line_free) begin
      sda_out_reg  <= 1'b1;
      sda_oe_n_reg <= 1'b1;
    end else if (scl_fall) begin
      if (drive_ack) begin
        sda_out_reg  <= 1'b0;
        sda_oe_n_reg <= 1'b0;
      end else if (rd_active) begin
        sda_out_reg  <= rd_bit;
        sda_oe_n_reg <= rd_bit;
      end else begin
        sda_out_reg  <= 1'b1;
        sda_oe_n_reg <= 1'b1;
      end
    end
  end
  // open drain: only a low is ever driven
  assign sda_out  = sda_out_reg;
  assign sda_oe_n = sda_oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register writes from the serial port; bytes aimed at the status offset
  // or at unmapped offsets are acknowledged but dropped
  wire wr_fmt  = wr_strobe & (ptr_reg == `SCP_OFS_OUT_FORMAT);
  wire wr_bw   = wr_strobe & (ptr_reg == `SCP_OFS_BW_PLL);
  wire wr_red  = wr_strobe & (ptr_reg == `SCP_OFS_RED_TARGET);
  wire wr_grn  = wr_strobe & (ptr_reg == `SCP_OFS_GREEN_TARGET);
  wire wr_blu  = wr_strobe & (ptr_reg == `SCP_OFS_BLUE_TARGET);
  wire wr_aofs = wr_strobe & (ptr_reg == `SCP_OFS_AOFS_CTRL);

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fmt_reg       <= `SCP_RST_OUT_FORMAT;
      bw_reg        <= `SCP_RST_BW_PLL;
      red_tgt_reg   <= `SCP_RST_TARGET;
      green_tgt_reg <= `SCP_RST_TARGET;
      blue_tgt_reg  <= `SCP_RST_TARGET;
      aofs_reg      <= `SCP_RST_AOFS_CTRL;
    end else begin
      if (wr_fmt)  fmt_reg       <= rx_byte;
      if (wr_bw)   bw_reg        <= rx_byte;
      if (wr_red)  red_tgt_reg   <= rx_byte;
      if (wr_grn)  green_tgt_reg <= rx_byte;
      if (wr_blu)  blue_tgt_reg  <= rx_byte;
      if (wr_aofs) aofs_reg      <= rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode for the analog and output logic
  wire [1:0] sog_code = bw_reg[`SCP_BIT_SOG_BW_HI:`SCP_BIT_SOG_BW_LO];
  scp_sog_bw_t sog_bw;
  assign sog_bw = (sog_code == 2'h0) ? SCP_SOG_BW_300M
                : (sog_code == 2'h3) ? SCP_SOG_BW_6M5 : SCP_SOG_BW_13M;
  wire [7:0] rate = (aofs_reg[1:0] == 2'h0) ? `SCP_RATE_EVERY
                  : (aofs_reg[1:0] == 2'h1) ? `SCP_RATE_16
                  : `SCP_RATE_64;
  wire fmt444 = fmt_reg[`SCP_BIT_FMT_444];

  // outputs registered; they lag the registers by one edge, a cycle traded
  // for outputs that come straight from flops
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl          <= '0;
      red_is_chroma <= 1'b0;
      green_is_luma <= 1'b0;
      blue_oe_n     <= 1'b0;
    end else begin
      ctrl.fmt_444        <= fmt444;
      ctrl.pll_extra_div2 <= bw_reg[`SCP_BIT_PLL_DIV2];
      ctrl.sog_bw         <= sog_bw;
      ctrl.analog_bw_7m   <= bw_reg[`SCP_BIT_ANA_BW];
      ctrl.aofs_enable    <= aofs_reg[`SCP_BIT_AOFS_EN];
      ctrl.aofs_hold      <= aofs_reg[`SCP_BIT_AOFS_HOLD];
      ctrl.aofs_rate      <= rate;
      ctrl.red_target     <= red_tgt_reg;
      ctrl.green_target   <= green_tgt_reg;
      ctrl.blue_target    <= blue_tgt_reg;
      red_is_chroma       <= ~fmt444;
      green_is_luma       <= ~fmt444;
      blue_oe_n           <= ~fmt444;
    end
  end
endmodule
`default_nettype wire

// file: verif/scp_regs_properties.sv
// concurrent checks on the serial control port pins and decoded controls
`timescale 1ns/1ps
`default_nettype none
module scp_regs_checker
  import scp_pkg::*;
(
  input wire logic      clk,
  input wire logic      rstn,
  input wire logic      scl_in,
  input wire logic      sda_in,
  input wire logic      sda_out,
  input wire logic      sda_oe_n,
  input wire logic      address_select_pins,
  input wire logic      coast_polarity_in,
  input wire scp_ctrl_t ctrl,
  input wire logic      red_is_chroma,
  input wire logic      green_is_luma,
  input wire logic      blue_oe_n
);
  logic [3:0] up_cnt;
  logic [3:0] hi_cnt;
  // cycles since reset; controls load a few edges after release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) up_cnt <= 4'h0;
    else if (up_cnt != 4'hF) up_cnt <= up_cnt + 4'h1;
  end
  // clock line high far longer than a bit time means the bus is idle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) hi_cnt <= 4'h0;
    else if (!scl_in) hi_cnt <= 4'h0;
    else if (hi_cnt != 4'hF) hi_cnt <= hi_cnt + 4'h1;
  end
  wire logic settled = (up_cnt == 4'hF);
  wire logic bus_idle = (hi_cnt == 4'hF);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_take_drive;
    $fell(sda_oe_n);
  endsequence
  sequence s_mode_422;
    red_is_chroma && green_is_luma && blue_oe_n;
  endsequence
  sequence s_mode_444;
    !red_is_chroma && !green_is_luma && !blue_oe_n;
  endsequence

  ////////////////////////////////////////////////////////////////////
  a_drive_only_low: assert property (!sda_oe_n |-> !sda_out)
    else $error("data line driven high");
  a_drive_in_low: assert property (s_take_drive |-> $past(scl_in, 2) == 1'b0)
    else $error("data drive taken while clock high");
  a_release_on_idle: assert property (bus_idle |-> sda_oe_n)
    else $error("data line held on idle bus");
  a_ctrl_quiet_idle: assert property (settled && bus_idle |-> $stable(ctrl))
    else $error("controls changed with no transfer");
  a_fmt_422_out: assert property (settled && !ctrl.fmt_444 |-> ##[0:2] s_mode_422)
    else $error("4:2:2 outputs not set");
  a_fmt_444_out: assert property (settled && ctrl.fmt_444 |-> ##[0:2] s_mode_444)
    else $error("4:4:4 outputs not set");
  a_mode_pair: assert property (red_is_chroma == green_is_luma)
    else $error("red and green modes differ");
  a_sog_legal: assert property (settled |-> ctrl.sog_bw != 2'h3)
    else $error("illegal green sync bandwidth");
  a_rate_legal: assert property (settled |-> ctrl.aofs_rate inside {8'h01, 8'h10, 8'h40})
    else $error("illegal update rate");
endmodule
bind scp_regs scp_regs_checker scp_regs_checker_i (.clk(clk), .rstn(rstn), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .address_select_pins(address_select_pins), .coast_polarity_in(coast_polarity_in),
  .ctrl(ctrl), .red_is_chroma(red_is_chroma), .green_is_luma(green_is_luma),
  .blue_oe_n(blue_oe_n));
`default_nettype wire

// file: verif/scp_host_model.sv
// two-wire bus master model: drives the clock line and pulls data low
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // clock stands high and data is released outside frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one bit: data moves 20 ns into the low phase, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    #20 sda_low = ~b;
    #4 scl = 1'b1;
    #23 r = sda;
    #1 scl = 1'b0;
  endtask
  // start from idle, or repeated start from mid-frame
  task automatic start();
    if (!scl) begin
      #20 sda_low = 1'b0;
      #4 scl = 1'b1;
    end
    #12 sda_low = 1'b1;
    #12 scl = 1'b0;
  endtask
  task automatic stop();
    #20 sda_low = 1'b1;
    #4 scl = 1'b1;
    #12 sda_low = 1'b0;
    #24;
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rx(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, r);
  endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
// register access testbench for the serial control port
`timescale 1ns/1ps
`default_nettype none
`include "scp_defs.svh"
module tb
  import scp_pkg::*;
;
  logic       clk, rstn, scl, m_low, sel, coast;
  logic       sda_out, sda_oe_n, red_is_chroma, green_is_luma, blue_oe_n;
  logic [7:0] b;
  logic       a;
  scp_ctrl_t  ctrl;
  scp_sog_bw_t bw_exp;
  int         failures, num_checks, cyc;
  logic [7:0] rates [4] = '{8'h01, 8'h10, 8'h40, 8'h40};
  // open-drain wire with pull-up
  wire logic  sda = ~(m_low | ~(sda_oe_n | sda_out));

  scp_regs scp_regs_i (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_select_pins(sel),
    .coast_polarity_in(coast), .ctrl(ctrl), .red_is_chroma(red_is_chroma),
    .green_is_luma(green_is_luma), .blue_oe_n(blue_oe_n));
  scp_host_model scp_host_model_i (.scl(scl), .sda_low(m_low), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] adr(input logic rd);
    return {`SCP_SLAVE_ADDR_HI, sel, rd};
  endfunction
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
    logic k;
    @(posedge clk) #1; // frames open off the sampling edge
    scp_host_model_i.start();
    scp_host_model_i.tx(adr(1'b0), k);
    check("address ack", k, 8'h01);
    scp_host_model_i.tx(ptr, k);
    check("pointer ack", k, 8'h01);
    foreach (d[i]) begin
      scp_host_model_i.tx(d[i], k);
      check("data ack", k, 8'h01);
    end
    scp_host_model_i.stop();
    repeat (4) @(posedge clk);
  endtask
  // pointer written first, then repeated start into the read
  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp[$]);
    logic k;
    logic [7:0] v;
    @(posedge clk) #1; // frames open off the sampling edge
    scp_host_model_i.start();
    scp_host_model_i.tx(adr(1'b0), k);
    scp_host_model_i.tx(ptr, k);
    scp_host_model_i.start();
    scp_host_model_i.tx(adr(1'b1), k);
    check("read ack", k, 8'h01);
    foreach (exp[i]) begin
      scp_host_model_i.rx(i != exp.size() - 1, v);
      check("read data", v, exp[i]);
    end
    #30 check("released", sda, 8'h01);
    scp_host_model_i.stop();
    repeat (4) @(posedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // hang guard: the whole run needs roughly 10000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    num_checks = 0;
    cyc = 0;
    rstn = 1'b0;
    sel = 1'b0;
    coast = 1'b0;
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (12) @(posedge clk);
    check("format reset", ctrl.fmt_444, 8'h01);
    check("rate reset", ctrl.aofs_rate, `SCP_RATE_64);
    check("aofs reset", {ctrl.aofs_enable, ctrl.aofs_hold}, 8'h00);
    rd(8'h19, '{8'h04, 8'h04, 8'h04});
    rd(8'h1D, '{8'h02});
    $display("test reset values done");
    wr(8'h19, '{8'hA5, 8'h5A, 8'h3C});
    check("targets", ctrl.red_target ^ ctrl.green_target ^ ctrl.blue_target, 8'hC3);
    rd(8'h19, '{8'hA5, 8'h5A, 8'h3C});
    $display("test burst access done");
    wr(8'h15, '{8'h00});
    check("4:2:2 mode", {red_is_chroma, green_is_luma, blue_oe_n, ctrl.fmt_444}, 8'h0E);
    wr(8'h15, '{8'h02});
    check("4:4:4 mode", {red_is_chroma, green_is_luma, blue_oe_n, ctrl.fmt_444}, 8'h01);
    $display("test output format done");
    for (int i = 0; i < 4; i++) begin
      b = {i[0], i[1:0], i[1], 4'h0};
      wr(8'h16, '{b});
      rd(8'h16, '{b});
      check("extra divide", ctrl.pll_extra_div2, i[0]);
      check("analog bw", ctrl.analog_bw_7m, i[1]);
      bw_exp = (i == 0) ? SCP_SOG_BW_300M : (i == 3) ? SCP_SOG_BW_6M5 : SCP_SOG_BW_13M;
      check("sync bw", ctrl.sog_bw, bw_exp);
      b = {i[1], i[0], 4'h0, i[1:0]};
      wr(8'h1D, '{b});
      check("update rate", ctrl.aofs_rate, rates[i]);
      check("aofs bits", {ctrl.aofs_enable, ctrl.aofs_hold}, i[1:0]);
    end
    $display("test control fields done");
    for (int c = 0; c < 2; c++) begin
      @(posedge clk) #1 coast = c[0];
      wr(8'h14, '{8'hFF});
      rd(8'h14, '{{7'h00, c[0]}});
    end
    $display("test status done");
    @(posedge clk) #1 sel = 1'b1;
    scp_host_model_i.start();
    scp_host_model_i.tx({`SCP_SLAVE_ADDR_HI, 1'b0, 1'b0}, a);
    check("foreign address", a, 8'h00);
    scp_host_model_i.tx(8'h19, a);
    scp_host_model_i.tx(8'h77, a);
    check("ignored byte", a, 8'h00);
    scp_host_model_i.stop();
    wr(8'h1A, '{8'h11});
    rd(8'h19, '{8'hA5, 8'h11});
    $display("test address select done");
    // reset in mid-run must bring back the defaults written over above
    @(posedge clk) #1 rstn = 1'b0;
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (12) @(posedge clk);
    check("divide after reset", ctrl.pll_extra_div2, 8'h00);
    check("aofs after reset", {ctrl.aofs_enable, ctrl.aofs_hold}, 8'h00);
    rd(8'h15, '{8'h02, 8'h00});
    rd(8'h19, '{8'h04, 8'h04, 8'h04});
    rd(8'h1D, '{8'h02});
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
`default_nettype wire
